// File: design/padc_map.vh
`ifndef PADC_MAP_VH
`define PADC_MAP_VH
// Sample word width
`define PADC_DATA_W        12
// Encode cycles from hold edge to output
`define PADC_LATENCY       5
// Pipeline stage count
`define PADC_STAGES        4
// Bits resolved by each stage (no redundant bits; four stages give the 12-bit word)
`define PADC_STAGE_BITS    3
// Top code and bottom code of the range
`define PADC_CODE_MAX      12'hfff
`define PADC_CODE_MIN      12'h000
// Interrupt status bit positions
`define PADC_IRQ_WORD      0
`define PADC_IRQ_OVF       1
`define PADC_IRQ_W         2
// Register offsets (byte addresses)
`define PADC_REG_CTRL      4'h0
`define PADC_REG_STATUS    4'h4
`define PADC_REG_MASK      4'h8
`define PADC_REG_LAST      4'hc
// Control bit positions
`define PADC_CTRL_MSB_INVERT_CTL   0
`define PADC_CTRL_ENABLE_N 1
`endif

// File: design/padc_edge_sync.v
`timescale 1ns/1ns
// Two-flop synchroniser with rising and falling edge pulses
module padc_edge_sync (
   input  wire i_clk_sys,   // System clock
   input  wire i_rst_n,     // Async reset, active low
   input  wire i_async,     // Level from outside the domain
   output wire o_level,     // Synchronised level
   output wire o_rise,      // One-cycle pulse on rising edge
   output wire o_fall       // One-cycle pulse on falling edge
);
   reg meta;                // First stage, read only by sync
   reg sync;                // Second stage
   reg last;                // Previous synchronised level

   // Sample chain; edge detect sits after the second stage only
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= i_async;
         sync <= meta;
         last <= sync;
      end
   end

   assign o_level = sync;
   assign o_rise  = sync & ~last;
   assign o_fall  = ~sync & last;
endmodule // padc_edge_sync

// File: design/padc_stage.v
`timescale 1ns/1ns
`include "padc_map.vh"
// One pipelined quantiser stage: resolves bits and passes the residue
module padc_stage #(
   parameter RES_W  = 12,   // Residue width entering this stage
   parameter BITS   = 3     // Bits resolved here
) (
   input  wire             i_clk_sys,  // System clock
   input  wire             i_rst_n,    // Async reset, active low
   input  wire             i_step,     // Phase enable pulse
   input  wire [RES_W-1:0] i_res,      // Residue from previous stage
   output reg  [BITS-1:0]  o_code,     // Coarse code of this stage
   output reg  [RES_W-1:0] o_res       // Residue for next stage
);
   // Acquire on own phase; residue is input minus quantised part, rescaled
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_code <= {BITS{1'b0}};
         o_res  <= {RES_W{1'b0}};
      end else if (i_step) begin
         o_code <= i_res[RES_W-1 -: BITS];
         o_res  <= {i_res[RES_W-BITS-1:0], {BITS{1'b0}}};
      end
   end
endmodule // padc_stage

// File: design/padc_core.v
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "padc_map.vh"
module padc_core #(
   parameter DATA_W = `PADC_DATA_W,   // Output word width
   parameter LAT    = `PADC_LATENCY   // Encode cycles of latency
) (
   input  wire              i_clk_sys,        // System clock, 20 MHz
   input  wire              i_rst_n,          // Async reset, active low
   input  wire              i_encode_clk_p,   // Encode true input
   input  wire              i_encode_clk_n,   // Encode complement input
   input  wire [DATA_W-1:0] i_analog_code,    // Analog input as ideal code
   input  wire              i_analog_over,    // Input above top of range
   input  wire              i_analog_under,   // Input below bottom of range
   input  wire              i_msb_invert_ctl, // Pin: 0 two's comp, 1 offset bin
   input  wire              i_drive_enable_n, // Pin: low enables outputs
   input  wire [3:0]        i_addr,           // Register address
   input  wire [31:0]       i_wdata,          // Register write data
   input  wire              i_wr,             // Write strobe
   input  wire              i_rd,             // Read strobe
   output reg  [31:0]       o_rdata,          // Read data, one cycle later
   output wire [DATA_W-1:0] o_sample_bits,    // Data bus output value
   output wire [DATA_W-1:0] o_sample_bits_oe, // Data bus output enables
   output reg               o_range_overflow, // Over or under flow flag
   output reg               o_data_valid_strobe, // Capture strobe
   output wire              o_irq             // Level interrupt
);
   localparam SB = `PADC_STAGE_BITS;          // Bits per stage

   // Sync of pins from the encode side and from the board
   wire enc_true_lvl;    // Synchronised true encode
   wire enc_comp_lvl;    // Synchronised complement
   wire msb_invert_ctl_lvl;      // Synchronised format strap
   wire oe_n_lvl;        // Synchronised enable
   padc_edge_sync u_sync_p (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (i_encode_clk_p),
      .o_level   (enc_true_lvl),
      .o_rise    (),
      .o_fall    ()
   );
   padc_edge_sync u_sync_n (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (i_encode_clk_n),
      .o_level   (enc_comp_lvl),
      .o_rise    (),
      .o_fall    ()
   );
   padc_edge_sync u_sync_inv (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (i_msb_invert_ctl),
      .o_level   (msb_invert_ctl_lvl),
      .o_rise    (),
      .o_fall    ()
   );
   padc_edge_sync u_sync_oe (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (i_drive_enable_n),
      .o_level   (oe_n_lvl),
      .o_rise    (),
      .o_fall    ()
   );

   // Differential decision; equal inputs keep the previous phase
   reg  enc_hi;          // Resolved encode phase
   reg  enc_hi_d;        // Previous phase
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enc_hi   <= 1'b0;
         enc_hi_d <= 1'b0;
      end else begin
         if (enc_true_lvl & ~enc_comp_lvl)
            enc_hi <= 1'b1;
         else if (~enc_true_lvl & enc_comp_lvl)
            enc_hi <= 1'b0;
         enc_hi_d <= enc_hi;
      end
   end
   wire enc_rise = enc_hi & ~enc_hi_d;        // Hold edge
   wire enc_fall = ~enc_hi & enc_hi_d;        // Acquire edge

   // Sample and hold: tracks while low, frozen on rising edge
   reg [DATA_W-1:0] track;   // Tracked input
   reg              trk_ovr; // Tracked out-of-range
   reg [DATA_W-1:0] held;    // Held sample
   reg              held_ovr;
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         track    <= `PADC_CODE_MIN;
         trk_ovr  <= 1'b0;
         held     <= `PADC_CODE_MIN;
         held_ovr <= 1'b0;
      end else begin
         if (!enc_hi || enc_fall) begin
            if (i_analog_over)
               track <= `PADC_CODE_MAX;        // Clip at top
            else if (i_analog_under)
               track <= `PADC_CODE_MIN;        // Clip at bottom
            else
               track <= i_analog_code;
            trk_ovr <= i_analog_over | i_analog_under;
         end
         if (enc_rise) begin
            held     <= track;
            held_ovr <= trk_ovr;
         end
      end
   end

   // Four stages alternate: odd on falling edge, even on rising edge
   wire [SB-1:0]     c1, c2, c3, c4;    // Stage codes
   wire [DATA_W-1:0] r1, r2, r3, r4;    // Residues
   padc_stage #(.RES_W(DATA_W), .BITS(SB)) u_st1 (
      .i_clk_sys (i_clk_sys), .i_rst_n (i_rst_n), .i_step (enc_fall),
      .i_res (held), .o_code (c1), .o_res (r1));
   padc_stage #(.RES_W(DATA_W), .BITS(SB)) u_st2 (
      .i_clk_sys (i_clk_sys), .i_rst_n (i_rst_n), .i_step (enc_rise),
      .i_res (r1), .o_code (c2), .o_res (r2));
   padc_stage #(.RES_W(DATA_W), .BITS(SB)) u_st3 (
      .i_clk_sys (i_clk_sys), .i_rst_n (i_rst_n), .i_step (enc_fall),
      .i_res (r2), .o_code (c3), .o_res (r3));
   padc_stage #(.RES_W(DATA_W), .BITS(SB)) u_st4 (
      .i_clk_sys (i_clk_sys), .i_rst_n (i_rst_n), .i_step (enc_rise),
      .i_res (r3), .o_code (c4), .o_res (r4));

   // Align stage codes so one sample's codes meet at correction
   reg [SB-1:0] c1_d1, c1_d2, c1_d3;  // Stage one delay line
   reg [SB-1:0] c2_d1, c2_d2;         // Stage two delay line
   reg [SB-1:0] c3_d1;                // Stage three delay
   reg [3:0]    ovr_line;             // Flag delay to the output flag register
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         c1_d1 <= {SB{1'b0}}; c1_d2 <= {SB{1'b0}}; c1_d3 <= {SB{1'b0}};
         c2_d1 <= {SB{1'b0}}; c2_d2 <= {SB{1'b0}};
         c3_d1 <= {SB{1'b0}};
         ovr_line <= 4'h0;
      end else begin
         if (enc_rise) begin
            c1_d1 <= c1;
            c2_d1 <= c2;
            c1_d2 <= c1_d1;
         end
         if (enc_fall) begin
            c1_d3 <= c1_d2;
            c2_d2 <= c2_d1;
            c3_d1 <= c3;
         end
         if (enc_rise)
            ovr_line <= {ovr_line[2:0], held_ovr};
      end
   end

   // Correction: plain concatenation of the four stage codes, no overlap or redundant bit
   function [DATA_W-1:0] padc_combine;
      input [SB-1:0] a, b, c, d;
      begin
         padc_combine = {a, b, c, d};
      end
   endfunction

   // Output pipeline: corrected words step on rising encode edges
   // Extra stage makes the word arrive with its flag, five rises after hold
   reg [DATA_W-1:0] corr;     // Corrected word
   reg [DATA_W-1:0] mid_word; // Latency padding stage
   reg [DATA_W-1:0] out_word; // Word for the output buffer
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         corr             <= `PADC_CODE_MIN;
         mid_word         <= `PADC_CODE_MIN;
         out_word         <= `PADC_CODE_MIN;
         o_range_overflow <= 1'b0;
      end else if (enc_rise) begin
         corr             <= padc_combine(c1_d3, c2_d2, c3_d1, c4);
         mid_word         <= corr;
         out_word         <= mid_word;
         o_range_overflow <= ovr_line[3];
      end
   end

   // Format select; control register can override the pin
   reg ctrl_fmt_ovr;         // Software format override enable
   reg ctrl_oe_force_n;      // Software output disable
   wire fmt_offset = msb_invert_ctl_lvl & ~ctrl_fmt_ovr;
   wire [DATA_W-1:0] fmt_word =
      {out_word[DATA_W-1] ^ ~fmt_offset, out_word[DATA_W-2:0]};

   // Data bus and tri-state; bit 0 is LSB
   // Loaded only after a hold edge, so a format change never moves the
   // bus while the strobe is high
   reg [DATA_W-1:0] bus_q;   // Registered bus value
   reg              load_q;  // One cycle after the hold edge
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bus_q  <= `PADC_CODE_MIN;
         load_q <= 1'b0;
      end else begin
         load_q <= enc_rise;
         if (load_q)
            bus_q <= fmt_word;
      end
   end
   assign o_sample_bits    = bus_q;
   assign o_sample_bits_oe = {DATA_W{~oe_n_lvl & ~ctrl_oe_force_n}};

   // Strobe: low on hold edge, high on falling edge after data settled
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         o_data_valid_strobe <= 1'b0;
      else if (enc_rise)
         o_data_valid_strobe <= 1'b0;
      else if (enc_fall)
         o_data_valid_strobe <= 1'b1;
   end

   // Interrupt status: set wins over write-one clear
   reg [`PADC_IRQ_W-1:0] irq_stat;   // Sticky events
   reg [`PADC_IRQ_W-1:0] irq_mask;   // Enables
   wire [`PADC_IRQ_W-1:0] ev;
   assign ev[`PADC_IRQ_WORD] = enc_fall;
   assign ev[`PADC_IRQ_OVF]  = enc_fall & o_range_overflow;
   wire wr_ctrl = i_wr && (i_addr == `PADC_REG_CTRL);
   wire wr_stat = i_wr && (i_addr == `PADC_REG_STATUS);
   wire wr_mask = i_wr && (i_addr == `PADC_REG_MASK);
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat        <= {`PADC_IRQ_W{1'b0}};
         irq_mask        <= {`PADC_IRQ_W{1'b0}};
         ctrl_fmt_ovr    <= 1'b0;
         ctrl_oe_force_n <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~(wr_stat ? i_wdata[`PADC_IRQ_W-1:0]
                                            : {`PADC_IRQ_W{1'b0}})) | ev;
         if (wr_mask)
            irq_mask <= i_wdata[`PADC_IRQ_W-1:0];
         if (wr_ctrl) begin
            ctrl_fmt_ovr    <= i_wdata[`PADC_CTRL_MSB_INVERT_CTL];
            ctrl_oe_force_n <= i_wdata[`PADC_CTRL_ENABLE_N];
         end
      end
   end
   assign o_irq = |(irq_stat & irq_mask);

   // Read port; unmapped addresses return zero
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         o_rdata <= 32'h00000000;
      else if (i_rd) begin
         if (i_addr == `PADC_REG_CTRL)
            o_rdata <= {30'h0, ctrl_oe_force_n, ctrl_fmt_ovr};
         else if (i_addr == `PADC_REG_STATUS)
            o_rdata <= {30'h0, irq_stat};
         else if (i_addr == `PADC_REG_MASK)
            o_rdata <= {30'h0, irq_mask};
         else if (i_addr == `PADC_REG_LAST)
            o_rdata <= {19'h0, o_range_overflow, bus_q};
         else
            o_rdata <= 32'h00000000;
      end else
         o_rdata <= 32'h00000000;
   end
endmodule // padc_core

// File: sim/padc_core_props.sv
`timescale 1ns/1ns
// Pin and register port checks for the converter core
module padc_core_props #(
   parameter DATA_W = 12, // Word width
   parameter LAT    = 5   // Encode cycles of latency
) (
   input wire              i_clk_sys,
   input wire              i_rst_n,
   input wire              i_encode_clk_p,
   input wire              i_encode_clk_n,
   input wire              i_drive_enable_n,
   input wire [3:0]        i_addr,
   input wire [31:0]       i_wdata,
   input wire              i_wr,
   input wire              i_rd,
   input wire [31:0]       o_rdata,
   input wire [DATA_W-1:0] o_sample_bits,
   input wire [DATA_W-1:0] o_sample_bits_oe,
   input wire              o_range_overflow,
   input wire              o_data_valid_strobe,
   input wire              o_irq
);
   reg [2:0] up_cnt; // Cycles since reset; encode sync needs time to fill
   // Saturating count after reset
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) up_cnt <= 3'h0;
      else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   a_oe_uniform: assert property (&o_sample_bits_oe || !(|o_sample_bits_oe))
      else $error("Bus enables differ");
   a_pin_off: assert property (i_drive_enable_n [*3] |-> !(|o_sample_bits_oe))
      else $error("Bus driven while disabled");
   a_ctrl_off: assert property (i_wr && i_addr == 4'h0 && i_wdata[1] |=> !(|o_sample_bits_oe))
      else $error("Bus driven after disable write");
   a_strobe_fall: assert property (up_cnt == 3'h7 && $rose(i_encode_clk_p) && !i_encode_clk_n
      |-> ##[1:5] !o_data_valid_strobe) else $error("Strobe not low after encode rise");
   a_strobe_rise: assert property (up_cnt == 3'h7 && $fell(i_encode_clk_p) && i_encode_clk_n
      |-> ##[1:5] o_data_valid_strobe) else $error("Strobe not high after encode fall");
   a_word_hold: assert property (o_data_valid_strobe && $past(o_data_valid_strobe)
      |-> $stable({o_range_overflow, o_sample_bits})) else $error("Word moved under strobe");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("Read data without read");
   a_unmapped_rd: assert property (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == 32'h0)
      else $error("Unmapped read not zero");
   a_ctrl_readback: assert property (i_wr && i_addr == 4'h0 ##1 i_rd && i_addr == 4'h0
      |=> (o_rdata & 32'h3) == ($past(i_wdata, 2) & 32'h3)) else $error("Control readback");
   a_mask_quiet: assert property (i_wr && i_addr == 4'h8 && i_wdata == 32'h0 |=> !o_irq)
      else $error("Interrupt with mask clear");
endmodule // padc_core_props

bind padc_core padc_core_props #(.DATA_W(DATA_W), .LAT(LAT)) u_props (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_encode_clk_p(i_encode_clk_p),
   .i_encode_clk_n(i_encode_clk_n), .i_drive_enable_n(i_drive_enable_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_sample_bits(o_sample_bits), .o_sample_bits_oe(o_sample_bits_oe),
   .o_range_overflow(o_range_overflow), .o_data_valid_strobe(o_data_valid_strobe),
   .o_irq(o_irq));

// File: sim/padc_capture_model.sv
`timescale 1ns/1ns
// Far side: free-running encode source and a capture register
module padc_capture_model (
   input  wire        i_strobe,   // Data valid strobe
   input  wire [11:0] i_bus,      // Data bus as seen on the wires
   input  wire        i_ovf,      // Over or under flow flag
   output reg         o_enc_p,    // Encode true
   output wire        o_enc_n,    // Encode complement
   output reg  [11:0] o_word,     // Last captured word
   output reg         o_word_ovf, // Flag captured with it
   output int         o_fall_n,   // Encode falls before the capture
   output int         o_caps      // Captures so far
);
   int falls; // Encode falls so far; robust to a late strobe
   assign o_enc_n = ~o_enc_p;
   // Continuous 400 ns encode, eight system clocks, at a fixed phase offset from the system clock
   initial begin
      o_enc_p = 1'b0;
      falls = 0;
      #37;
      forever begin
         #200 o_enc_p = ~o_enc_p;
         if (!o_enc_p) falls = falls + 1;
      end
   end
   // Register word and flag on the strobe rising edge
   always @(posedge i_strobe) begin
      o_word     <= i_bus;
      o_word_ovf <= i_ovf;
      o_fall_n   <= falls;
      o_caps     <= o_caps + 1;
   end
endmodule // padc_capture_model

// File: sim/padc_core_tb.sv
`timescale 1ns/1ns
`include "padc_map.vh"
// Bench for the converter output port
module padc_core_tb;
   localparam logic [13:0] PAT [8] = '{14'h0000, 14'h0fff, 14'h0800, 14'h07ff,
                                       14'h0123, 14'h0a5c, 14'h2555, 14'h1555};
   reg          i_clk_sys = 1'b0;        // System clock
   reg          i_rst_n = 1'b0;          // Reset, active low
   reg  [11:0]  i_analog_code = 12'h000; // Ideal analog value
   reg          i_analog_over = 1'b0;    // Above range
   reg          i_analog_under = 1'b0;   // Below range
   reg          i_msb_invert_ctl = 1'b1; // Format pin
   reg          i_drive_enable_n = 1'b0; // Bus enable pin
   reg  [3:0]   i_addr = 4'h0;
   reg  [31:0]  i_wdata = 32'h0;
   reg          i_wr = 1'b0;
   reg          i_rd = 1'b0;
   wire [31:0]  o_rdata;
   wire [11:0]  o_sample_bits, o_sample_bits_oe, bus, cap_word;
   wire         o_range_overflow, o_data_valid_strobe, o_irq, enc_p, enc_n, cap_ovf;
   int          cap_fall, cap_n;
   reg  [11:0]  junk = 12'h000;          // Released bus lines wander
   reg          enc_q = 1'b0;            // Encode at previous edge
   reg          ovf_en = 1'b1;           // Allow out-of-range inputs
   reg  [2:0]   pat_i = 3'h0;            // Next pattern entry
   int          rn = 0;                  // Encode rises so far
   reg  [13:0]  sent [0:255];            // Input held at each rise
   int          failures = 0;
   int          cmp_count = 0;
   logic [31:0] rv;                      // Register read value
   always #25 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) junk <= ~junk;
   assign bus = (o_sample_bits & o_sample_bits_oe) | (junk & ~o_sample_bits_oe);
   // New input once encode is low, so it is tracked before the hold
   always @(posedge i_clk_sys) begin
      enc_q <= enc_p;
      if (enc_q && !enc_p) begin
         {i_analog_over, i_analog_under, i_analog_code} <= PAT[pat_i] & {ovf_en, ovf_en, 12'hfff};
         pat_i <= pat_i + 3'h1;
      end
   end
   // Remember what the hold edge froze
   always @(posedge enc_p) begin
      rn = rn + 1;
      sent[rn[7:0]] = {i_analog_over, i_analog_under, i_analog_code};
   end
   padc_core dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_encode_clk_p(enc_p),
      .i_encode_clk_n(enc_n), .i_analog_code(i_analog_code), .i_analog_over(i_analog_over),
      .i_analog_under(i_analog_under), .i_msb_invert_ctl(i_msb_invert_ctl),
      .i_drive_enable_n(i_drive_enable_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_sample_bits(o_sample_bits),
      .o_sample_bits_oe(o_sample_bits_oe), .o_range_overflow(o_range_overflow),
      .o_data_valid_strobe(o_data_valid_strobe), .o_irq(o_irq));
   padc_capture_model u_far (.i_strobe(o_data_valid_strobe), .i_bus(bus),
      .i_ovf(o_range_overflow), .o_enc_p(enc_p), .o_enc_n(enc_n), .o_word(cap_word),
      .o_word_ovf(cap_ovf), .o_fall_n(cap_fall), .o_caps(cap_n));
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task end_of_test();
      if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Both bus tasks start and end on a rising edge
   task reg_wr(input logic [3:0] a, input logic [31:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task reg_rd(input logic [3:0] a);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(negedge i_clk_sys);
      rv = o_rdata;
      @(posedge i_clk_sys);
   endtask
   // Wait for the next capture, bounded
   task wait_cap();
      int c0;
      c0 = cap_n;
      for (int i = 0; i < 40 && cap_n == c0; i++) @(posedge i_clk_sys);
      if (cap_n == c0) begin
         failures++;
         end_of_test();
      end
   endtask
   // First eight words are skipped so a format change can settle
   task check_words(input int n, input logic inv);
      logic [13:0] s;
      logic [11:0] c;
      repeat (8) wait_cap();
      repeat (n) begin
         wait_cap();
         s = sent[8'(cap_fall - 5)];
         c = s[13] ? 12'hfff : (s[12] ? 12'h000 : s[11:0]);
         check("sample word", {20'h0, cap_word}, {20'h0, c[11] ^ inv, c[10:0]});
         check("overflow flag", {31'h0, cap_ovf}, {31'h0, s[13] | s[12]});
      end
   endtask
   task peek(input string name, input logic [31:0] exp, input int which);
      repeat (4) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      check(name, which ? {31'h0, o_irq} : {20'h0, o_sample_bits_oe}, exp);
      @(posedge i_clk_sys);
   endtask
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      @(posedge i_clk_sys);
      reg_rd(`PADC_REG_CTRL);
      check("ctrl reset", rv, 32'h0);
      reg_rd(`PADC_REG_MASK);
      check("mask reset", rv, 32'h0);
      reg_rd(4'h2);
      check("unmapped", rv, 32'h0);
      check_words(8, 1'b0);
      i_msb_invert_ctl <= 1'b0;
      check_words(8, 1'b1);
      i_msb_invert_ctl <= 1'b1;
      reg_wr(`PADC_REG_CTRL, 32'h1);
      reg_rd(`PADC_REG_CTRL);
      check("ctrl", rv, 32'h1);
      check_words(8, 1'b1);
      reg_wr(`PADC_REG_CTRL, 32'h2);
      peek("oe ctrl off", 32'h0, 0);
      reg_wr(`PADC_REG_CTRL, 32'h0);
      i_drive_enable_n <= 1'b1;
      peek("oe pin off", 32'h0, 0);
      i_drive_enable_n <= 1'b0;
      peek("oe on", 32'hfff, 0);
      reg_rd(`PADC_REG_STATUS);
      check("status", rv, 32'h3);
      ovf_en <= 1'b0;
      repeat (10) wait_cap();
      reg_wr(`PADC_REG_STATUS, 32'h2);
      reg_wr(`PADC_REG_MASK, 32'h2);
      reg_rd(`PADC_REG_STATUS);
      check("status cleared", rv & 32'h2, 32'h0);
      peek("irq masked", 32'h0, 1);
      reg_wr(`PADC_REG_MASK, 32'h1);
      peek("irq word", 32'h1, 1);
      ovf_en <= 1'b1;
      reg_wr(`PADC_REG_MASK, 32'h2);
      repeat (10) wait_cap();
      peek("irq overflow", 32'h1, 1);
      reg_wr(`PADC_REG_MASK, 32'h0);
      peek("irq off", 32'h0, 1);
      end_of_test();
   end
endmodule // padc_core_tb
